// file: verilog/timer16_oc_pkg.sv
// constants for the 16-bit timer output compare block
package timer16_oc_pkg;
   localparam int COUNT_WIDTH = 16;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'h0000;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [15:0] TOP_8BIT = 16'h00FF;
   localparam logic [15:0] TOP_9BIT = 16'h01FF;
   localparam logic [15:0] TOP_10BIT = 16'h03FF;
   localparam logic [3:0] WGM_NORMAL = 4'h0;
   localparam logic [3:0] WGM_CTC_A = 4'h4;
   localparam logic [3:0] WGM_FAST_8 = 4'h5;
   localparam logic [3:0] WGM_FAST_9 = 4'h6;
   localparam logic [3:0] WGM_FAST_10 = 4'h7;
   localparam logic [3:0] WGM_CTC_CAP = 4'hC;
   localparam logic [3:0] WGM_FAST_CAP = 4'hE;
   localparam logic [3:0] WGM_FAST_A = 4'hF;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;
   localparam int CHAN_A = 0;
endpackage

// file: verilog/timer16_output_compare.sv
// output compare channels of a 16-bit timer with counter and port override
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - compare full count with each active value; match sets flag next timer tick.
// - enabled flag requests interrupt; cleared by service or software writing one.
// - channel A value can serve as counter top.
// - compare value double buffered in pwm modes, direct otherwise.
// - buffered value moves to active register only at top or bottom.
// - cpu writes reach buffer when buffering, else active register.
// - compare bytes read directly, never via high byte latch.
// - high byte goes to latch; low byte write updates all sixteen bits.
// - force strobe in non-pwm modes acts like match, no flag, no clear.
// - count write blocks all matches in next timer tick, even stopped.
// - count written equal to variable top skips top, runs to 0xFFFF.
// - output register holds across mode changes; reset or a clearing output action clears it.
// - action select not buffered; applies from next match or force.
// - nonzero action select routes compare output to pin; direction kept.
// - action select zero leaves output unchanged on matches.
// - non-pwm: set, clear or toggle; fast pwm: chooses polarity.
// - action select never changes counting sequence.
// - normal mode counts up and wraps; count writable any time.
// - overflow flag set when count becomes zero; cleared by service or software writing one.
// - clear-on-match mode clears on channel A (4) or capture value (12).
// - modes 5,6,7,14,15 are single-slope fast pwm restarting at bottom.
// - cpu count write beats any clear or count in same cycle.
module timer16_output_compare
   import timer16_oc_pkg::*;
#(
   parameter int CHANNELS = 3
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // timer clock enable and mode
   input wire logic timer_tick,
   input wire logic [3:0] waveform_select,
   input wire logic [15:0] capture_value,
   // counter access
   input wire logic count_write_low,
   input wire logic count_write_high,
   input wire logic [7:0] count_wdata,
   output logic [15:0] timer_count,
   // compare value access
   input wire logic [CHANNELS-1:0] compare_write_high,
   input wire logic [CHANNELS-1:0] compare_write_low,
   input wire logic [7:0] compare_wdata,
   output logic [CHANNELS*16-1:0] compare_value,
   // per channel control
   input wire logic [CHANNELS*2-1:0] output_action_select,
   input wire logic [CHANNELS-1:0] force_compare_strobe,
   input wire logic [CHANNELS-1:0] compare_interrupt_enable,
   input wire logic [CHANNELS-1:0] flag_clear_write,
   input wire logic [CHANNELS-1:0] compare_irq_ack,
   output logic [CHANNELS-1:0] compare_match_flag,
   output logic [CHANNELS-1:0] compare_irq,
   // overflow
   input wire logic overflow_enable,
   input wire logic overflow_clear_write,
   input wire logic overflow_irq_ack,
   output logic overflow_flag,
   output logic overflow_irq,
   // port pins
   input wire logic [CHANNELS-1:0] port_latch,
   input wire logic [CHANNELS-1:0] output_pin_direction,
   output logic [CHANNELS-1:0] compare_output,
   output logic [CHANNELS-1:0] pin_out,
   output logic [CHANNELS-1:0] pin_oe_n
);
   initial begin
      if (CHANNELS < 1 || CHANNELS > 3) begin
         $error("CHANNELS must be 1 to 3");
      end
      // compare and byte paths are built for a sixteen bit count
      if (COUNT_WIDTH != 16) begin
         $error("COUNT_WIDTH must be 16");
      end
   end

   function automatic logic is_pwm(input logic [3:0] wgm);
      is_pwm = !(wgm == WGM_NORMAL || wgm == WGM_CTC_A || wgm == WGM_CTC_CAP || wgm == 4'h8 || wgm == 4'hD);
   endfunction

   function automatic logic is_fast(input logic [3:0] wgm);
      is_fast = (wgm == WGM_FAST_8) || (wgm == WGM_FAST_9) || (wgm == WGM_FAST_10) ||
                (wgm == WGM_FAST_CAP) || (wgm == WGM_FAST_A);
   endfunction

   // shared byte latch always supplies the upper half
   function automatic logic [15:0] word_of(input logic [7:0] hi, input logic [7:0] lo);
      word_of = {hi, lo};
   endfunction

   // non-pwm action on a match or force
   function automatic logic act_result(input logic [1:0] act, input logic cur);
      case (act)
         ACT_TOGGLE: act_result = !cur;
         ACT_CLEAR: act_result = 1'b0;
         ACT_SET: act_result = 1'b1;
         default: act_result = cur;
      endcase
   endfunction

   logic rst_meta;
   logic rst_sync;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   logic [15:0] count;
   logic [15:0] next_count;
   logic [7:0] high_byte_latch;
   logic [7:0] next_high_byte_latch;
   logic block_pending;
   logic next_block_pending;
   logic [15:0] active_val [CHANNELS];
   logic [15:0] buffer_val [CHANNELS];
   logic [15:0] next_active_val [CHANNELS];
   logic [15:0] next_buffer_val [CHANNELS];
   logic [CHANNELS-1:0] flag;
   logic [CHANNELS-1:0] next_flag;
   logic [CHANNELS-1:0] ocout;
   logic [CHANNELS-1:0] next_ocout;
   logic ovf;
   logic next_ovf;
   logic [15:0] top;
   logic pwm;
   logic fast;
   logic at_top;
   logic at_bottom_next;

   always_comb begin
      pwm = is_pwm(waveform_select);
      fast = is_fast(waveform_select);
      case (waveform_select)
         WGM_CTC_A, WGM_FAST_A: top = active_val[CHAN_A];
         WGM_CTC_CAP, WGM_FAST_CAP: top = capture_value;
         WGM_FAST_8: top = TOP_8BIT;
         WGM_FAST_9: top = TOP_9BIT;
         WGM_FAST_10: top = TOP_10BIT;
         default: top = COUNT_MAX;
      endcase
      // top match is blocked too after a count write, so count runs on to max
      at_top = (count == top) && !block_pending && (waveform_select != WGM_NORMAL);
      at_bottom_next = timer_tick && (at_top || count == COUNT_MAX);
   end

   logic count_written;
   always_comb begin
      next_count = count;
      next_high_byte_latch = high_byte_latch;
      next_block_pending = block_pending;
      count_written = count_write_low;
      next_ovf = ovf;
      if (count_write_high || (|compare_write_high)) begin
         next_high_byte_latch = count_write_high ? count_wdata : compare_wdata;
      end
      // clear first so a tick without overflow cannot swallow the clear
      if (overflow_irq_ack || overflow_clear_write) begin
         next_ovf = 1'b0;
      end
      if (timer_tick) begin
         next_block_pending = 1'b0;
         if (at_top) begin
            next_count = COUNT_BOTTOM;
         end else begin
            next_count = count + 16'h0001;
         end
         // set beats a clear in the same cycle
         if (next_count == COUNT_BOTTOM) begin
            next_ovf = 1'b1;
         end
      end
      if (count_written) begin
         next_count = word_of(high_byte_latch, count_wdata);
         next_block_pending = 1'b1;
      end
   end

   logic [CHANNELS-1:0] match;
   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         logic [1:0] act;
         logic [15:0] wval;
         act = output_action_select[i*2 +: 2];
         wval = word_of(high_byte_latch, compare_wdata);
         next_active_val[i] = active_val[i];
         next_buffer_val[i] = buffer_val[i];
         next_flag[i] = flag[i];
         next_ocout[i] = ocout[i];
         match[i] = timer_tick && (count == active_val[i]) && !block_pending;
         if (compare_write_low[i]) begin
            if (pwm) begin
               next_buffer_val[i] = wval;
            end else begin
               next_active_val[i] = wval;
               next_buffer_val[i] = wval;
            end
         end
         if (pwm && at_bottom_next) begin
            next_active_val[i] = next_buffer_val[i];
         end
         if (compare_irq_ack[i] || flag_clear_write[i]) begin
            next_flag[i] = 1'b0;
         end
         if (match[i]) begin
            next_flag[i] = 1'b1;
         end
         if (act != ACT_NONE) begin
            if (!pwm) begin
               if (match[i] || force_compare_strobe[i]) begin
                  next_ocout[i] = act_result(act, ocout[i]);
               end
            end else if (fast) begin
               // polarity only; compare hit beats bottom when value equals top
               if (at_bottom_next) begin
                  next_ocout[i] = (act == ACT_CLEAR);
               end
               if (match[i] && act[1]) begin
                  next_ocout[i] = (act == ACT_SET);
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         count <= COUNT_RESET;
         high_byte_latch <= LATCH_RESET;
         block_pending <= 1'b0;
         ovf <= 1'b0;
         flag <= '0;
         ocout <= '0;
         for (int i = 0; i < CHANNELS; i++) begin
            active_val[i] <= COMPARE_RESET;
            buffer_val[i] <= COMPARE_RESET;
         end
      end else begin
         count <= next_count;
         high_byte_latch <= next_high_byte_latch;
         block_pending <= next_block_pending;
         ovf <= next_ovf;
         flag <= next_flag;
         ocout <= next_ocout;
         for (int i = 0; i < CHANNELS; i++) begin
            active_val[i] <= next_active_val[i];
            buffer_val[i] <= next_buffer_val[i];
         end
      end
   end

   // outputs registered from next state, on the same edge as internal state
   logic [CHANNELS*16-1:0] next_cv_out;
   logic [CHANNELS-1:0] next_pin_out;
   logic [CHANNELS-1:0] next_irq;
   logic next_ovf_irq;
   logic [CHANNELS-1:0] next_oe_n;
   always_comb begin
      next_irq = next_flag & compare_interrupt_enable;
      next_ovf_irq = next_ovf & overflow_enable;
      // direction taken one cycle late, like every other output
      next_oe_n = ~output_pin_direction;
      for (int i = 0; i < CHANNELS; i++) begin
         // software sees buffer in pwm modes; bytes read straight, no latch
         next_cv_out[i*16 +: 16] = pwm ? next_buffer_val[i] : next_active_val[i];
         next_pin_out[i] = (|output_action_select[i*2 +: 2]) ? next_ocout[i] : port_latch[i];
      end
   end

   always_ff @(posedge core_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         timer_count <= COUNT_RESET;
         compare_value <= '0;
         compare_match_flag <= '0;
         compare_irq <= '0;
         overflow_flag <= 1'b0;
         overflow_irq <= 1'b0;
         compare_output <= '0;
         pin_out <= '0;
         pin_oe_n <= '1;
      end else begin
         timer_count <= next_count;
         compare_value <= next_cv_out;
         compare_match_flag <= next_flag;
         compare_irq <= next_irq;
         overflow_flag <= next_ovf;
         overflow_irq <= next_ovf_irq;
         compare_output <= next_ocout;
         pin_out <= next_pin_out;
         pin_oe_n <= next_oe_n;
      end
   end
endmodule // timer16_output_compare
`default_nettype wire

// file: verif/timer16_oc_checker.sv
// concurrent checks on the output compare block ports
`timescale 1ns/10ps
`default_nettype none
module timer16_oc_checker
   import timer16_oc_pkg::*;
#(parameter int CHANNELS = 3) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // counter side
   input wire logic timer_tick,
   input wire logic [3:0] waveform_select,
   input wire logic count_write_low,
   input wire logic count_write_high,
   input wire logic [7:0] count_wdata,
   input wire logic [15:0] timer_count,
   input wire logic overflow_flag,
   // channel side
   input wire logic [CHANNELS*16-1:0] compare_value,
   input wire logic [CHANNELS*2-1:0] output_action_select,
   input wire logic [CHANNELS-1:0] flag_clear_write,
   input wire logic [CHANNELS-1:0] compare_match_flag,
   input wire logic [CHANNELS-1:0] compare_output,
   input wire logic [CHANNELS-1:0] output_pin_direction,
   input wire logic [CHANNELS-1:0] pin_oe_n
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic blk;
   logic next_blk;
   logic nrm;
   // block lasts until the next timer tick, however late it comes
   always_comb begin
      next_blk = count_write_low ? 1'b1 : (timer_tick ? 1'b0 : blk);
      nrm = (waveform_select == WGM_NORMAL);
   end
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         blk <= 1'b0;
      end else begin
         blk <= next_blk;
      end
   end
   AST_MATCH_FLAG: assert property (nrm && timer_tick && !blk && !count_write_low &&
      timer_count == compare_value[15:0] |=> compare_match_flag[0]) else $error("match did not set flag");
   AST_MATCH_BLOCK: assert property (nrm && timer_tick && blk && !compare_match_flag[0]
      |=> !compare_match_flag[0]) else $error("match not blocked after count write");
   AST_SW_CLEAR: assert property (flag_clear_write[0] && !timer_tick |=> !compare_match_flag[0])
      else $error("software clear ignored");
   AST_HOLD_NONE: assert property (output_action_select[1:0] == ACT_NONE ##1 output_action_select[1:0] ==
      ACT_NONE |-> $stable(compare_output[0])) else $error("output moved with no action");
   AST_COUNT_LOAD: assert property (count_write_high ##1 count_write_low |=>
      timer_count == {$past(count_wdata, 2), $past(count_wdata)}) else $error("count word load wrong");
   AST_COUNT_INC: assert property (nrm && timer_tick && !count_write_low |=>
      timer_count == $past(timer_count) + 16'h0001) else $error("normal count step wrong");
   AST_OVF_SET: assert property (nrm && timer_tick && !count_write_low && timer_count == COUNT_MAX
      |=> overflow_flag && timer_count == COUNT_BOTTOM) else $error("overflow not flagged");
   AST_OE_DIR: assert property ($stable(output_pin_direction[0])[*2] |->
      pin_oe_n[0] == !output_pin_direction[0]) else $error("pin drive does not follow direction");
   cover property (compare_match_flag[0]);
   cover property (timer_tick && blk);
   cover property (overflow_flag);
endmodule // timer16_oc_checker
bind timer16_output_compare timer16_oc_checker #(.CHANNELS(CHANNELS)) u_chk (.*);
`default_nettype wire

// file: verif/cpu_bus_model.sv
// cpu side model: byte writes to count and compare words
`timescale 1ns/10ps
`default_nettype none
module cpu_bus_model #(parameter int CHANNELS = 3) (
   // clock
   input wire logic core_clk,
   // byte write strobes and data
   output logic count_write_low,
   output logic count_write_high,
   output logic [CHANNELS-1:0] compare_write_high,
   output logic [CHANNELS-1:0] compare_write_low,
   output logic [7:0] wdata
);
   initial begin
      {count_write_low, count_write_high} = 2'h0;
      {compare_write_high, compare_write_low} = '0;
      wdata = 8'h00;
   end
   // high byte first into the shared latch, low byte completes the word
   task automatic wr16(input logic is_cnt, input int ch, input logic [15:0] v);
      @(posedge core_clk);
      count_write_high <= is_cnt;
      compare_write_high <= is_cnt ? '0 : CHANNELS'(1) << ch;
      wdata <= v[15:8];
      @(posedge core_clk);
      {count_write_high, compare_write_high} <= '0;
      count_write_low <= is_cnt;
      compare_write_low <= is_cnt ? '0 : CHANNELS'(1) << ch;
      wdata <= v[7:0];
      @(posedge core_clk);
      {count_write_low, compare_write_low} <= '0;
      // data no longer valid once the strobe drops
      wdata <= ~v[7:0];
      #1;
   endtask
endmodule // cpu_bus_model
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the output compare block
`timescale 1ns/10ps
`default_nettype none
module tb;
   import timer16_oc_pkg::*;
   typedef struct {logic [1:0] act; logic exp;} row_s;
   row_s rows[6] = '{'{ACT_SET, 1'b1}, '{ACT_TOGGLE, 1'b0}, '{ACT_TOGGLE, 1'b1},
      '{ACT_NONE, 1'b1}, '{ACT_CLEAR, 1'b0}, '{ACT_SET, 1'b1}};
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic timer_tick = 1'b0;
   logic [3:0] waveform_select = WGM_NORMAL;
   logic [15:0] capture_value = 16'h0000;
   logic [5:0] output_action_select = 6'h00;
   logic [2:0] force_compare_strobe = 3'h0;
   logic [2:0] compare_interrupt_enable = 3'h0;
   logic [2:0] flag_clear_write = 3'h0;
   logic [2:0] compare_irq_ack = 3'h0;
   logic overflow_enable = 1'b0;
   logic overflow_clear_write = 1'b0;
   logic overflow_irq_ack = 1'b0;
   logic [2:0] port_latch = 3'h0;
   logic [2:0] output_pin_direction = 3'h0;
   logic count_write_low, count_write_high, overflow_flag, overflow_irq;
   logic [2:0] compare_write_high, compare_write_low, compare_match_flag, compare_irq;
   logic [2:0] compare_output, pin_out, pin_oe_n;
   logic [7:0] wdata;
   logic [15:0] timer_count;
   logic [47:0] compare_value;
   wire [7:0] count_wdata = wdata;
   wire [7:0] compare_wdata = wdata;
   int mismatches = 0;
   int total_checks = 0;
   int cycles = 0;
   timer16_output_compare u_dut (.*);
   cpu_bus_model u_cpu (.core_clk(core_clk), .count_write_low(count_write_low), .count_write_high(count_write_high),
      .compare_write_high(compare_write_high), .compare_write_low(compare_write_low), .wdata(wdata));
   always #5 core_clk = ~core_clk;
   // ceiling well above the roughly 650 cycles the sequence needs
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge core_clk) timer_tick <= 1'b1;
         @(posedge core_clk) timer_tick <= 1'b0;
      end
      #1;
   endtask
   task automatic hit(input logic [2:0] f, input logic [2:0] c, input logic [2:0] a);
      @(posedge core_clk);
      {force_compare_strobe, flag_clear_write, compare_irq_ack} <= {f, c, a};
      @(posedge core_clk);
      {force_compare_strobe, flag_clear_write, compare_irq_ack} <= 9'h000;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge core_clk);
      compare_interrupt_enable <= 3'h1;
      #1;
      chk("reset count", timer_count, 16'h0000);
      chk("reset oe_n", {13'h0, pin_oe_n}, 16'h0007);
      chk("reset output", {13'h0, compare_output}, 16'h0000);
      // set up the output before enabling the pin
      foreach (rows[i]) begin
         @(posedge core_clk) output_action_select <= {4'h0, rows[i].act};
         hit(3'h1, 3'h0, 3'h0);
         chk("forced output", 16'(compare_output[0]), 16'(rows[i].exp));
         chk("forced flag", 16'(compare_match_flag[0]), 16'h0000);
      end
      @(posedge core_clk) output_pin_direction <= 3'h1;
      hit(3'h0, 3'h0, 3'h0);
      chk("pin override", {14'h0, pin_out[0], pin_oe_n[0]}, 16'h0002);
      @(posedge core_clk) output_action_select <= 6'h00;
      hit(3'h0, 3'h0, 3'h0);
      chk("pin port latch", 16'(pin_out[0]), 16'h0000);
      u_cpu.wr16(1'b0, 0, 16'h1234);
      chk("compare word", compare_value[15:0], 16'h1234);
      u_cpu.wr16(1'b1, 0, 16'h1234);
      ticks(1);
      chk("blocked flag", 16'(compare_match_flag[0]), 16'h0000);
      u_cpu.wr16(1'b1, 0, 16'h1230);
      ticks(5);
      chk("match flag", {timer_count[3:0], 11'h0, compare_match_flag[0]}, 16'h5001);
      hit(3'h0, 3'h0, 3'h0);
      chk("irq", 16'(compare_irq[0]), 16'h0001);
      hit(3'h0, 3'h0, 3'h1);
      chk("ack clear", {14'h0, compare_match_flag[0], compare_irq[0]}, 16'h0000);
      u_cpu.wr16(1'b1, 0, 16'h1233);
      ticks(2);
      hit(3'h0, 3'h1, 3'h0);
      chk("write-one clear", 16'(compare_match_flag[0]), 16'h0000);
      u_cpu.wr16(1'b1, 0, 16'hFFFF);
      ticks(1);
      chk("overflow", {timer_count[14:0], overflow_flag}, 16'h0001);
      @(posedge core_clk) overflow_enable <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      chk("overflow irq", 16'(overflow_irq), 16'h0001);
      // ack lands together with a tick that does not overflow
      @(posedge core_clk) {overflow_irq_ack, timer_tick} <= 2'h3;
      @(posedge core_clk) {overflow_irq_ack, timer_tick} <= 2'h0;
      #1;
      chk("overflow ack", {14'h0, overflow_flag, overflow_irq}, 16'h0000);
      // that tick hit the zero compare words of the other two channels
      hit(3'h0, 3'h6, 3'h0);
      @(posedge core_clk) waveform_select <= WGM_FAST_8;
      @(posedge core_clk) output_action_select <= 6'h01;
      hit(3'h1, 3'h0, 3'h0);
      chk("pwm force ignored", 16'(compare_output[0]), 16'h0001);
      u_cpu.wr16(1'b0, 1, 16'h0010);
      u_cpu.wr16(1'b1, 0, 16'h0005);
      ticks(12);
      chk("buffered flag", 16'(compare_match_flag[1]), 16'h0000);
      ticks(238);
      chk("top", timer_count, 16'h00FF);
      ticks(1);
      chk("bottom", timer_count, 16'h0000);
      ticks(17);
      chk("loaded flag", {14'h0, compare_match_flag[1:0]}, 16'h0002);
      end_sim();
   end
endmodule // tb
`default_nettype wire
